// ==== shared/apd_pkg.sv ====
/*
 * Package for the analog power-down control block: register byte addresses,
 * field positions, reset values and AXI4-Lite response codes.
 * Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
 */
`default_nettype none

package apd_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [31:0] WAKE_CFG_ADDR = 32'h40048234;
    localparam logic [31:0] RUN_CFG_ADDR  = 32'h40048238;
    localparam logic [31:0] CTRL_ADDR     = 32'h4004823c;

    // ------------------------------------------------------------------
    // Field positions of both power registers
    // ------------------------------------------------------------------
    localparam int OSC_OUT_BIT   = 0;
    localparam int OSC_CORE_BIT  = 1;
    localparam int FLASH_BIT     = 2;
    localparam int BROWNOUT_BIT  = 3;
    localparam int CONVERTER_BIT = 4;
    localparam int SYS_OSC_BIT   = 5;
    localparam int WD_OSC_BIT    = 6;
    localparam int SYS_PLL_BIT   = 7;
    localparam int USB_PLL_BIT   = 8;
    localparam int FIXED0_BIT    = 9;
    localparam int USB_PAD_BIT   = 10;
    localparam int FIXED1_BIT    = 11;
    localparam int CFG_WIDTH     = 12;

    // Reset value, shared by both registers
    localparam logic [11:0] CFG_RESET = 12'hdf0;
    // Bits that software may change; fixed bits keep their value
    localparam logic [11:0] CFG_WMASK = 12'h5ff;

    // Control register: bit 0 is a wake-up event strobe (write 1)
    localparam int WAKE_STROBE_BIT = 0;

    // Clean-point delay for the oscillator core, in system clock cycles
    localparam logic [3:0] GATE_DELAY = 4'h4;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : apd_pkg

`default_nettype wire

// ==== src/apd_gate.sv ====
/*
 * Glitch-free gate for the oscillator core power-down.
 * Assumes one clock; the request is a level from the run register.
 */
`timescale 1ns/10ps
`default_nettype none

module apd_gate (
    input  wire logic clk,      // System clock
    input  wire logic reset_n,  // Synchronous reset, active low
    input  wire logic clk_en,   // Freezes state when low
    input  wire logic req_off,  // Requested core power-down
    output logic      core_off  // Applied core power-down
);
    typedef enum logic [2:0] {
        GS_ON   = 3'b001,
        GS_WAIT = 3'b010,
        GS_OFF  = 3'b100
    } apd_gate_st_t;

    apd_gate_st_t st_q;
    logic [3:0]   cnt_q;

    // --------------------------------------------------------------
    // Power-down waits a fixed count so the clock stops at a clean edge
    // --------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_q  <= GS_ON;
            cnt_q <= 4'h0;
        end else if (clk_en) begin
            case (st_q)
                GS_ON: begin
                    if (req_off) begin
                        st_q  <= GS_WAIT;
                        cnt_q <= apd_pkg::GATE_DELAY;
                    end
                end
                GS_WAIT: begin
                    if (!req_off) begin
                        st_q <= GS_ON;           // Cancelled before gating
                    end else if (cnt_q == 4'h1) begin
                        st_q <= GS_OFF;
                    end
                    cnt_q <= cnt_q - 4'h1;
                end
                GS_OFF: begin
                    if (!req_off) begin
                        st_q <= GS_ON;           // Power-up is immediate
                    end
                end
                default: st_q <= GS_ON;
            endcase
        end
    end

    assign core_off = (st_q == GS_OFF);

    gate_delay_a: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && st_q == GS_ON && req_off)
        ##1 (clk_en && req_off) [*4] |=> core_off)
        else $error("core power-down not applied after delay");
endmodule : apd_gate

`default_nettype wire

// ==== src/apd_top.sv ====
/*
 * Analog power-down control: run-time and wake-up power registers on
 * AXI4-Lite, driving power-down levels of the analog blocks.
 * Assumes the wake-up event arrives as a one-cycle pulse on the clock.
 */
// Behaviour
// - Field 0 powers the block, field 1 powers it down
// - Run register bits 0..8 blocks, bit 10 USB pad, 31:12 reserved
// - Run reset: oscillator, flash, brown-out on; the rest off
// - USB pad field 1 suspends the USB PHY, 0 keeps it powered
// - Run writes take effect at once, except oscillator core
// - Oscillator core stops only at a clean point, possibly delayed
// - Wake-up register holds the state taken after Deep-sleep
// - Wake-up register mirrors run layout and reset values
`timescale 1ns/10ps
`default_nettype none

module apd_top (
    input  wire logic        clk,               // System clock, 10 MHz
    input  wire logic        reset_n,           // Synchronous reset, active low
    input  wire logic        clk_en,            // Freezes all state when low
    input  wire logic        wake_event,        // Deep-sleep wake-up pulse
    input  wire logic [31:0] s_axi_awaddr,      // Write address
    input  wire logic        s_axi_awvalid,     // Write address valid
    output logic             s_axi_awready,     // Write address ready
    input  wire logic [31:0] s_axi_wdata,       // Write data
    input  wire logic [3:0]  s_axi_wstrb,       // Write byte strobes
    input  wire logic        s_axi_wvalid,      // Write data valid
    output logic             s_axi_wready,      // Write data ready
    output logic [1:0]       s_axi_bresp,       // Write response
    output logic             s_axi_bvalid,      // Write response valid
    input  wire logic        s_axi_bready,      // Write response ready
    input  wire logic [31:0] s_axi_araddr,      // Read address
    input  wire logic        s_axi_arvalid,     // Read address valid
    output logic             s_axi_arready,     // Read address ready
    output logic [31:0]      s_axi_rdata,       // Read data
    output logic [1:0]       s_axi_rresp,       // Read response
    output logic             s_axi_rvalid,      // Read data valid
    input  wire logic        s_axi_rready,      // Read data ready
    output logic             osc_output_off,    // Oscillator output down
    output logic             osc_core_off,      // Oscillator core down
    output logic             flash_off,         // Flash down
    output logic             brownout_off,      // Brown-out detector down
    output logic             converter_off,     // ADC down
    output logic             system_osc_off,    // System oscillator down
    output logic             watchdog_osc_off,  // Watchdog oscillator down
    output logic             system_pll_off,    // System PLL down
    output logic             usb_pll_off,       // USB PLL down
    output logic             usb_pad_off        // USB PHY in suspend
);
    logic [11:0] run_cfg_q;
    logic [11:0] wake_cfg_q;
    logic [31:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        aw_have_q;
    logic        w_have_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic        wr_fire;
    logic        wake_strobe;

    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    // Byte-strobed merge; fixed reserved bits are never changed, which
    // protects the analog trims from a careless write
    function automatic logic [11:0] merge_cfg(input logic [11:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  st);
        logic [11:0] m;
        m = {{4{st[1]}}, {8{st[0]}}} & apd_pkg::CFG_WMASK;
        merge_cfg = (old & ~m) | (wd[11:0] & m);
    endfunction : merge_cfg

    function automatic logic is_mapped(input logic [31:0] a);
        is_mapped = (a == apd_pkg::WAKE_CFG_ADDR) || (a == apd_pkg::RUN_CFG_ADDR)
                 || (a == apd_pkg::CTRL_ADDR);
    endfunction : is_mapped

    // --------------------------------------------------------------
    // Write channel: address and data taken in either order
    // --------------------------------------------------------------
    // Ready stays low while frozen, so the master never sees a beat taken that was lost
    assign s_axi_awready = clk_en && !aw_have_q && !bvalid_q;
    assign s_axi_wready  = clk_en && !w_have_q && !bvalid_q;
    assign wr_fire       = aw_have_q && w_have_q && !bvalid_q;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awaddr_q  <= 32'h0;
            wdata_q   <= 32'h0;
            wstrb_q   <= 4'h0;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_have_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_have_q <= 1'b0;
            end
        end
    end

    // Write response one cycle after both halves are held
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            bvalid_q <= 1'b0;
            bresp_q  <= apd_pkg::RESP_OKAY;
        end else if (clk_en) begin
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q  <= is_mapped(awaddr_q) ? apd_pkg::RESP_OKAY : apd_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;
    assign wake_strobe  = wr_fire && (awaddr_q == apd_pkg::CTRL_ADDR)
                       && wstrb_q[0] && wdata_q[apd_pkg::WAKE_STROBE_BIT];

    // --------------------------------------------------------------
    // Power registers
    // --------------------------------------------------------------
    // Wake-up load wins over a same-cycle software write to run config
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            run_cfg_q <= apd_pkg::CFG_RESET;
        end else if (clk_en) begin
            if (wake_event || wake_strobe) begin
                run_cfg_q <= wake_cfg_q;
            end else if (wr_fire && awaddr_q == apd_pkg::RUN_CFG_ADDR) begin
                run_cfg_q <= merge_cfg(run_cfg_q, wdata_q, wstrb_q);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wake_cfg_q <= apd_pkg::CFG_RESET;
        end else if (clk_en) begin
            if (wr_fire && awaddr_q == apd_pkg::WAKE_CFG_ADDR) begin
                wake_cfg_q <= merge_cfg(wake_cfg_q, wdata_q, wstrb_q);
            end
        end
    end

    // --------------------------------------------------------------
    // Read channel: one cycle latency, reserved bits 31:12 read as zero
    // --------------------------------------------------------------
    assign s_axi_arready = clk_en && !rvalid_q;   // No address taken while frozen

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0;
            rresp_q  <= apd_pkg::RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_arvalid && s_axi_arready) begin
                rvalid_q <= 1'b1;
                rresp_q  <= is_mapped(s_axi_araddr) ? apd_pkg::RESP_OKAY
                                                    : apd_pkg::RESP_SLVERR;
                case (s_axi_araddr)
                    apd_pkg::WAKE_CFG_ADDR: rdata_q <= {20'h0, wake_cfg_q};
                    apd_pkg::RUN_CFG_ADDR:  rdata_q <= {20'h0, run_cfg_q};
                    default:                rdata_q <= 32'h0;
                endcase
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;

    // --------------------------------------------------------------
    // Analog power-down levels; 1 means powered down
    // --------------------------------------------------------------
    apd_gate u_gate (
        .clk      (clk),
        .reset_n  (reset_n),
        .clk_en   (clk_en),
        .req_off  (run_cfg_q[apd_pkg::OSC_CORE_BIT]),
        .core_off (osc_core_off)
    );

    assign osc_output_off   = run_cfg_q[apd_pkg::OSC_OUT_BIT];
    assign flash_off        = run_cfg_q[apd_pkg::FLASH_BIT];
    assign brownout_off     = run_cfg_q[apd_pkg::BROWNOUT_BIT];
    assign converter_off    = run_cfg_q[apd_pkg::CONVERTER_BIT];
    assign system_osc_off   = run_cfg_q[apd_pkg::SYS_OSC_BIT];
    assign watchdog_osc_off = run_cfg_q[apd_pkg::WD_OSC_BIT];
    assign system_pll_off   = run_cfg_q[apd_pkg::SYS_PLL_BIT];
    assign usb_pll_off      = run_cfg_q[apd_pkg::USB_PLL_BIT];
    assign usb_pad_off      = run_cfg_q[apd_pkg::USB_PAD_BIT];

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    sequence run_write_s;
        clk_en && wr_fire && awaddr_q == apd_pkg::RUN_CFG_ADDR && wstrb_q == 4'hf
        && !wake_event && !wake_strobe;
    endsequence

    run_immediate_a: assert property (@(posedge clk) disable iff (!reset_n)
        run_write_s |=> (usb_pll_off == $past(wdata_q[8]) && converter_off == $past(wdata_q[4])))
        else $error("run write not applied next cycle");

    usb_pad_a: assert property (@(posedge clk) disable iff (!reset_n)
        run_write_s |=> usb_pad_off == $past(wdata_q[10]))
        else $error("usb pad field not applied");

    reset_value_a: assert property (@(posedge clk)
        !reset_n |=> (run_cfg_q == apd_pkg::CFG_RESET && wake_cfg_q == apd_pkg::CFG_RESET))
        else $error("power registers wrong after reset");

    wake_load_a: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && wake_event) |=> run_cfg_q == $past(wake_cfg_q))
        else $error("wake-up state not loaded");

    wake_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && wr_fire && awaddr_q == apd_pkg::WAKE_CFG_ADDR && wstrb_q == 4'hf)
        |=> wake_cfg_q[8:0] == $past(wdata_q[8:0]))
        else $error("wake-up register not written");

    fixed_bits_a: assert property (@(posedge clk) disable iff (!reset_n)
        run_cfg_q[11] && !run_cfg_q[9] && wake_cfg_q[11] && !wake_cfg_q[9])
        else $error("fixed reserved bits changed");

    field_map_a: assert property (@(posedge clk) disable iff (!reset_n)
        (osc_output_off == run_cfg_q[0] && flash_off == run_cfg_q[2]
         && brownout_off == run_cfg_q[3] && system_osc_off == run_cfg_q[5]))
        else $error("power level does not follow field");

    read_run_a: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && s_axi_arvalid && s_axi_arready && s_axi_araddr == apd_pkg::RUN_CFG_ADDR)
        |=> (rvalid_q && rdata_q[31:12] == 20'h0 && rdata_q[11:0] == $past(run_cfg_q)))
        else $error("run register read wrong");

    core_delay_a: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(run_cfg_q[1]) |-> !osc_core_off)
        else $error("core gated without delay");
endmodule : apd_top

`default_nettype wire

// ==== verification/tb_analog_power_down_control.sv ====
/*
 * Self-checking bench for the analog power-down control block.
 * Assumes apd_top with an AXI4-Lite slave; the bench acts as bus master.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_analog_power_down_control;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        clk_en = 1'b1;
    logic        wake_event = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic        osc_output_off, osc_core_off, flash_off, brownout_off, converter_off;
    logic        system_osc_off, watchdog_osc_off, system_pll_off, usb_pll_off, usb_pad_off;
    int          miscompares = 0;
    int          compares = 0;

    // 10 MHz system clock
    always #50 clk = ~clk;

    apd_top u_dut (
        .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .wake_event(wake_event),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .osc_output_off(osc_output_off), .osc_core_off(osc_core_off), .flash_off(flash_off),
        .brownout_off(brownout_off), .converter_off(converter_off),
        .system_osc_off(system_osc_off), .watchdog_osc_off(watchdog_osc_off),
        .system_pll_off(system_pll_off), .usb_pll_off(usb_pll_off), .usb_pad_off(usb_pad_off)
    );

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Power-down outputs packed in register layout, fixed bits filled in
    function automatic logic [31:0] outs();
        return {20'h0, 1'b1, usb_pad_off, 1'b0, usb_pll_off, system_pll_off,
                watchdog_osc_off, system_osc_off, converter_off, brownout_off,
                flash_off, osc_core_off, osc_output_off};
    endfunction : outs

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    // Entered just after a rising edge; ready is sampled on the falling
    // edge so the decision never races the design's own updates
    task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] resp);
        logic aw_hit, w_hit, b_hit;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        forever begin
            @(negedge clk);
            aw_hit = s_axi_awvalid && s_axi_awready;
            w_hit  = s_axi_wvalid && s_axi_wready;
            b_hit  = s_axi_bvalid && s_axi_bready;
            resp   = s_axi_bresp;
            @(posedge clk);
            if (aw_hit) s_axi_awvalid <= 1'b0;
            if (w_hit) s_axi_wvalid <= 1'b0;
            if (b_hit) begin
                s_axi_bready <= 1'b0;
                break;
            end
        end
        // Idle edge so a following call never reassigns bready in this step
        @(posedge clk);
    endtask : axi_write

    task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] resp);
        logic ar_hit, r_hit;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        forever begin
            @(negedge clk);
            ar_hit = s_axi_arvalid && s_axi_arready;
            r_hit  = s_axi_rvalid && s_axi_rready;
            d      = s_axi_rdata;
            resp   = s_axi_rresp;
            @(posedge clk);
            if (ar_hit) s_axi_arvalid <= 1'b0;
            if (r_hit) begin
                s_axi_rready <= 1'b0;
                break;
            end
        end
        // Idle edge so a following call never reassigns rready in this step
        @(posedge clk);
    endtask : axi_read

    // Read a register and compare data and response
    task automatic read_chk(input logic [31:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        logic [1:0]  r;
        axi_read(a, d, r);
        check(d, exp, what);
        check({30'h0, r}, {30'h0, apd_pkg::RESP_OKAY}, "read response");
    endtask : read_chk

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    // Reset, also used last to prove a second reset restores defaults
    task automatic test_reset();
        reset_n <= 1'b0;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        check(outs(), 32'hdf0, "outputs after reset");
        read_chk(apd_pkg::RUN_CFG_ADDR, 32'hdf0, "run reset value");
        read_chk(apd_pkg::WAKE_CFG_ADDR, 32'hdf0, "wake reset value");
        $display("test_reset done");
    endtask : test_reset

    // Walk one power-down bit over every field; the USB PLL stays down
    // so dropping the system oscillator never starves it
    task automatic test_fields();
        int          pos[10] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 10};
        logic [31:0] exp;
        logic [1:0]  r;
        foreach (pos[i]) begin
            exp = 32'h900 | (32'h1 << pos[i]);
            axi_write(apd_pkg::RUN_CFG_ADDR, exp, r);
            @(negedge clk);
            check(outs() & 32'h5fd, exp & 32'h5fd, "immediate fields");
            if (pos[i] == 1) check({31'h0, osc_core_off}, 32'h0, "core not yet gated");
            repeat (8) @(negedge clk);
            check(outs(), exp, "settled fields");
            @(posedge clk);
            read_chk(apd_pkg::RUN_CFG_ADDR, exp, "run readback");
        end
        // Fixed bits ignore what is written, upper bits read zero
        axi_write(apd_pkg::RUN_CFG_ADDR, 32'hffffffff, r);
        read_chk(apd_pkg::RUN_CFG_ADDR, 32'hdff, "run all ones");
        axi_write(apd_pkg::RUN_CFG_ADDR, 32'h0, r);
        read_chk(apd_pkg::RUN_CFG_ADDR, 32'h800, "run all zeros");
        check(outs(), 32'h800, "all powered");
        $display("test_fields done");
    endtask : test_fields

    // Clock enable low freezes the registers: a wake-up pulse is lost
    task automatic test_freeze();
        clk_en     <= 1'b0;
        wake_event <= 1'b1;
        @(posedge clk);
        wake_event <= 1'b0;
        @(negedge clk);
        check(outs(), 32'h800, "frozen by clock enable");
        check({30'h0, s_axi_awready, s_axi_arready}, 32'h0, "no beat taken frozen");
        @(posedge clk);
        clk_en <= 1'b1;
        @(posedge clk);
        $display("test_freeze done");
    endtask : test_freeze

    // Wake-up loads the run register from the wake register, by pin pulse and by control strobe
    task automatic test_wake();
        logic [1:0] r;
        axi_write(apd_pkg::WAKE_CFG_ADDR, 32'hffffffff, r);
        read_chk(apd_pkg::WAKE_CFG_ADDR, 32'hdff, "wake all ones");
        axi_write(apd_pkg::WAKE_CFG_ADDR, 32'h9a6, r);
        check(outs(), 32'h800, "wake write leaves run alone");
        wake_event <= 1'b1;
        @(posedge clk);
        wake_event <= 1'b0;
        @(negedge clk);
        check(outs() & 32'h5fd, 32'h9a6 & 32'h5fd, "wake loads fields");
        repeat (8) @(negedge clk);
        check(outs(), 32'h9a6, "wake core settled");
        @(posedge clk);
        read_chk(apd_pkg::RUN_CFG_ADDR, 32'h9a6, "run after wake");
        axi_write(apd_pkg::RUN_CFG_ADDR, 32'h800, r);
        axi_write(apd_pkg::CTRL_ADDR, 32'h1, r);
        read_chk(apd_pkg::RUN_CFG_ADDR, 32'h9a6, "run after strobe");
        read_chk(apd_pkg::CTRL_ADDR, 32'h0, "control reads zero");
        $display("test_wake done");
    endtask : test_wake

    // Unmapped address answers with an error and changes nothing
    task automatic test_unmapped();
        logic [31:0] d;
        logic [1:0]  r;
        axi_write(32'h40048240, 32'hffffffff, r);
        check({30'h0, r}, {30'h0, apd_pkg::RESP_SLVERR}, "unmapped write response");
        axi_read(32'h40048240, d, r);
        check({30'h0, r}, {30'h0, apd_pkg::RESP_SLVERR}, "unmapped read response");
        check(d, 32'h0, "unmapped read data");
        read_chk(apd_pkg::RUN_CFG_ADDR, 32'h9a6, "run unchanged");
        $display("test_unmapped done");
    endtask : test_unmapped

    task automatic close_out();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out

    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        test_reset();
        test_fields();
        test_freeze();
        test_wake();
        test_unmapped();
        test_reset();
        close_out();
    end

    // Whole run needs well under 1000 cycles; this only cuts a hang short
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        close_out();
    end
endmodule : tb_analog_power_down_control

`default_nettype wire
